// file: adc_seq_ctl.sv
// Converter channel, reference and sequencing control with Avalon-MM registers.
// Behaviour
// - Reference code 011 selects both external; top bit one selects supply/ground.
// - Scan bit steps enabled inputs for channel 0 positive on multiplexer A.
// - Channel count 00 converts channel 0, 01 channels 0-1, 1x channels 0-3.
// - In 12-bit mode the channel count reads zero, only channel 0 converts.
// - Fill status is one while second buffer half fills, zero for first.
// - Without DMA, interrupt after every N-th conversion, N is low four bits plus one.
// - With DMA, advance buffer address every N-th conversion, N full field plus one.
// - Negative select one routes input 1, zero the low reference.
// - Positive codes 00000 to 01111 select analog inputs 0 to 15.
// - Codes 11000 to 11010 pick op-amp outputs if enabled, else shared pins.
// - Code 11110 temperature diode, 11111 open, 11011 to 11101 reserved.
`timescale 1ns/1ps
module adc_seq_ctl #(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Converter core.
    input wire logic conv_done,
    input wire logic [15:0] conv_data,
    input wire logic [15:0] scan_enables,
    // Result buffer sink.
    output logic res_valid,
    input wire logic res_ready,
    output logic [15:0] res_data,
    output logic [1:0] res_chan,
    output logic res_half,
    // Analog front end control.
    output adc_ctl_pkg::ref_sel_t ref_sel,
    output adc_ctl_pkg::mux_route_t route_ch0,
    output logic [1:0] conv_chan,
    output logic use_mux_b,
    output logic conv_irq,
    output logic dma_advance
);
    logic [15:0] ctrl2_ff;
    logic [15:0] chsel_ff;
    logic [15:0] ctrl_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic err_ff;
    logic fill_ff;
    logic [4:0] evt_ff;
    logic [1:0] chan_ff;
    logic [3:0] scan_ff;
    logic irq_ff;
    logic dma_ff;
    logic overrun_ff;
    logic res_valid_ff;
    adc_ctl_pkg::result_t res_ff;
    adc_ctl_pkg::ref_sel_t ref_ff;
    adc_ctl_pkg::mux_route_t route_ff;

    // Register decode.
    wire req = (avs_read || avs_write) && !ack_ff;
    wire hit2 = avs_address == adc_ctl_pkg::ctrl2_off;
    wire hitc = avs_address == adc_ctl_pkg::chsel_off;
    wire hitk = avs_address == adc_ctl_pkg::ctrl_off;
    wire hits = avs_address == adc_ctl_pkg::status_off;
    wire mapped = hit2 || hitc || hitk || hits;
    wire [15:0] bemask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // A write lands at the edge where the master sees waitrequest low.
    wire wr_go = ack_ff && avs_write && mapped;

    // Field views.
    wire twelve = ctrl_ff[adc_ctl_pkg::twelve_bit];
    wire dma_en = ctrl_ff[adc_ctl_pkg::dma_bit];
    wire [2:0] opamps = ctrl_ff[adc_ctl_pkg::opamp_lsb +: 3];
    wire [2:0] refcode = ctrl2_ff[adc_ctl_pkg::ref_lsb +: 3];
    wire scan_en = ctrl2_ff[adc_ctl_pkg::scan_bit];
    wire [1:0] channel_count_select_raw = ctrl2_ff[adc_ctl_pkg::channel_count_select_lsb +: 2];
    wire [1:0] channel_count_select = twelve ? 2'h0 : channel_count_select_raw;
    wire [4:0] rate = ctrl2_ff[adc_ctl_pkg::rate_lsb +: 5];
    wire split = ctrl2_ff[adc_ctl_pkg::split_bit];
    wire [4:0] posa = chsel_ff[adc_ctl_pkg::posa_lsb +: 5];
    wire [4:0] posb = chsel_ff[adc_ctl_pkg::posb_lsb +: 5];

    // Reference selection.
    wire [1:0] nxt_ref =
        refcode[2] ? adc_ctl_pkg::ref_avdd_avss : refcode[1:0];

    // Channel stepping: last channel is 0, 1 or 3 depending on count.
    wire [1:0] last_chan = channel_count_select[1] ? 2'h3 : {1'b0, channel_count_select[0]};
    wire accept = conv_done;
    wire wrap = accept && chan_ff == last_chan;

    // Scan picks the next enabled input after the present one.
    logic [3:0] scan_next;
    always_comb begin
        scan_next = scan_ff;
        for (int i = 15; i >= 1; i--) begin
            if (scan_enables[4'(scan_ff + 4'(i))]) begin
                scan_next = 4'(scan_ff + 4'(i));
            end
        end
    end
    wire [4:0] pos_a_eff = scan_en ? {1'b0, scan_ff} : posa;
    wire [4:0] pos_sel = use_mux_b ? posb : pos_a_eff;
    wire neg_sel = use_mux_b ? chsel_ff[adc_ctl_pkg::negb_bit] :
                   chsel_ff[adc_ctl_pkg::nega_bit];
    adc_ctl_pkg::mux_route_t nxt_route;

    adc_input_decode u_decode (
        .pos_code(pos_sel),
        .neg_sel(neg_sel),
        .opamp_enable(opamps),
        .route(nxt_route)
    );

    // Event count for interrupt or DMA pacing.
    wire [4:0] limit = dma_en ? rate : {1'b0, rate[3:0]};
    wire evt_hit = accept && evt_ff >= limit;
    wire [4:0] nxt_evt = evt_hit ? 5'h00 : (accept ? evt_ff + 5'h01 : evt_ff);

    // Results pass the FIFO; a full FIFO drops the sample and flags it.
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready = !res_valid_ff || res_ready;
    wire [17:0] fifo_out_data;
    wire fifo_push = accept && fifo_in_ready;

    adc_result_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(accept),
        .in_ready(fifo_in_ready),
        .in_data({conv_data, chan_ff}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Read mux.
    wire [15:0] ctrl2_view = {ctrl2_ff[15:10], channel_count_select,
                              fill_ff, ctrl2_ff[6:0]};
    wire [15:0] status_view = {13'h0000, overrun_ff, chan_ff};
    wire [15:0] rmux = hit2 ? ctrl2_view : hitc ? chsel_ff :
                       hitk ? ctrl_ff : hits ? status_view : 16'h0000;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= req;
            rdata_ff <= {16'h0000, rmux};
            err_ff <= req && !mapped;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl2_ff <= adc_ctl_pkg::ctrl2_reset;
            chsel_ff <= adc_ctl_pkg::chsel_reset;
            ctrl_ff <= adc_ctl_pkg::ctrl_reset;
        end else if (wr_go) begin
            if (hit2) begin
                ctrl2_ff <= (ctrl2_ff & ~(bemask & adc_ctl_pkg::ctrl2_wmask)) |
                    (avs_writedata[15:0] & bemask & adc_ctl_pkg::ctrl2_wmask);
            end
            if (hitc) begin
                chsel_ff <= (chsel_ff & ~(bemask & adc_ctl_pkg::chsel_wmask)) |
                    (avs_writedata[15:0] & bemask & adc_ctl_pkg::chsel_wmask);
            end
            if (hitk) begin
                ctrl_ff <= (ctrl_ff & ~(bemask & adc_ctl_pkg::ctrl_wmask)) |
                    (avs_writedata[15:0] & bemask & adc_ctl_pkg::ctrl_wmask);
            end
        end
    end

    // Sequencer state; overrun is set by a drop and cleared by writing status.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chan_ff <= 2'h0;
            scan_ff <= 4'h0;
            evt_ff <= 5'h00;
            fill_ff <= 1'b0;
            irq_ff <= 1'b0;
            dma_ff <= 1'b0;
            overrun_ff <= 1'b0;
            ref_ff <= adc_ctl_pkg::ref_avdd_avss;
            route_ff <= '0;
        end else begin
            chan_ff <= wrap ? 2'h0 : (accept ? chan_ff + 2'h1 : chan_ff);
            if (accept && scan_en && !use_mux_b) begin
                scan_ff <= scan_next;
            end
            evt_ff <= nxt_evt;
            if (evt_hit && split) begin
                fill_ff <= !fill_ff;
            end else if (!split) begin
                fill_ff <= 1'b0;
            end
            irq_ff <= evt_hit && !dma_en;
            dma_ff <= evt_hit && dma_en;
            overrun_ff <= (accept && !fifo_in_ready) ||
                          (overrun_ff && !(wr_go && hits));
            ref_ff <= adc_ctl_pkg::ref_sel_t'(nxt_ref);
            route_ff <= nxt_route;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            res_valid_ff <= 1'b0;
            res_ff <= '0;
        end else if (fifo_out_ready) begin
            res_valid_ff <= fifo_out_valid;
            res_ff <= adc_ctl_pkg::result_t'(fifo_out_data);
        end
    end

    // Sample multiplexer B is used on the second half of alternating runs.
    logic mux_b_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mux_b_ff <= 1'b0;
        end else begin
            mux_b_ff <= ctrl2_ff[0] && wrap ? !mux_b_ff :
                        (ctrl2_ff[0] ? mux_b_ff : 1'b0);
        end
    end

    assign avs_waitrequest = !ack_ff;
    assign avs_readdata = rdata_ff;
    assign avs_response = err_ff ? 2'h2 : 2'h0;
    assign res_valid = res_valid_ff;
    assign res_data = res_ff.data;
    assign res_chan = res_ff.chan;
    assign res_half = fill_ff;
    assign ref_sel = ref_ff;
    assign route_ch0 = route_ff;
    assign conv_chan = chan_ff;
    assign use_mux_b = mux_b_ff;
    assign conv_irq = irq_ff;
    assign dma_advance = dma_ff;

    property p_ref_ext;
        @(posedge clk) disable iff (reset)
        refcode == adc_ctl_pkg::ref_ext_both |=> ref_sel == adc_ctl_pkg::ref_ext_ext;
    endproperty
    a_ref_ext: assert property (p_ref_ext) else $error("ref 011 wrong");
    property p_ref_top;
        @(posedge clk) disable iff (reset)
        refcode[2] |=> ref_sel == adc_ctl_pkg::ref_avdd_avss;
    endproperty
    a_ref_top: assert property (p_ref_top) else $error("ref 1xx wrong");
    property p_chps12;
        @(posedge clk) disable iff (reset) twelve |-> channel_count_select == 2'h0;
    endproperty
    a_chps12: assert property (p_chps12) else $error("channel_count_select in 12-bit");
    property p_chan_range;
        @(posedge clk) disable iff (reset)
        accept && channel_count_select == 2'h0 |=> conv_chan == 2'h0;
    endproperty
    a_chan_range: assert property (p_chan_range) else $error("chan range");
    property p_irq;
        @(posedge clk) disable iff (reset)
        accept && !dma_en && evt_ff == {1'b0, rate[3:0]} |=> conv_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_dma;
        @(posedge clk) disable iff (reset)
        accept && dma_en && evt_ff == rate |=> dma_advance && !conv_irq;
    endproperty
    a_dma: assert property (p_dma) else $error("dma missing");
    property p_fill;
        @(posedge clk) disable iff (reset)
        evt_hit && split |=> fill_ff != $past(fill_ff);
    endproperty
    a_fill: assert property (p_fill) else $error("fill toggle");
    property p_temp;
        @(posedge clk) disable iff (reset)
        pos_sel == adc_ctl_pkg::pos_temp |=>
            route_ch0.kind == adc_ctl_pkg::src_temp;
    endproperty
    a_temp: assert property (p_temp) else $error("temp route");
    property p_pin;
        @(posedge clk) disable iff (reset)
        pos_sel <= adc_ctl_pkg::pos_last_pin |=>
            route_ch0.index == $past(pos_sel);
    endproperty
    a_pin: assert property (p_pin) else $error("pin route");
    c_irq: cover property (@(posedge clk) conv_irq);
    c_dma: cover property (@(posedge clk) dma_advance);
    c_full: cover property (@(posedge clk) accept && !fifo_in_ready);
endmodule

// file: adc_ctl_pkg.sv
// Package with register map, field layout and encodings of the converter control slice.
package adc_ctl_pkg;
    // Register byte addresses (word aligned).
    localparam logic [3:0] ctrl2_off = 4'h0;
    localparam logic [3:0] chsel_off = 4'h4;
    localparam logic [3:0] ctrl_off = 4'h8;
    localparam logic [3:0] status_off = 4'hc;
    // Control register 2 fields.
    localparam int ref_lsb = 13;
    localparam int scan_bit = 10;
    localparam int channel_count_select_lsb = 8;
    localparam int fill_bit = 7;
    localparam int rate_lsb = 2;
    localparam int split_bit = 1;
    localparam logic [15:0] ctrl2_wmask = 16'he77f;
    localparam logic [15:0] ctrl2_reset = 16'h0000;
    // Channel 0 select register fields.
    localparam int negb_bit = 15;
    localparam int posb_lsb = 8;
    localparam int nega_bit = 7;
    localparam int posa_lsb = 0;
    localparam logic [15:0] chsel_wmask = 16'h9f9f;
    localparam logic [15:0] chsel_reset = 16'h0000;
    // Own control register fields.
    localparam int twelve_bit = 0;
    localparam int dma_bit = 1;
    localparam int opamp_lsb = 2;
    localparam logic [15:0] ctrl_wmask = 16'h001f;
    localparam logic [15:0] ctrl_reset = 16'h0000;
    // Reference codes.
    localparam logic [2:0] ref_ext_both = 3'h3;
    // Positive input codes.
    localparam logic [4:0] pos_last_pin = 5'h0f;
    localparam logic [4:0] pos_opamp1 = 5'h18;
    localparam logic [4:0] pos_opamp3 = 5'h1a;
    localparam logic [4:0] pos_temp = 5'h1e;
    localparam logic [4:0] pos_open = 5'h1f;
    localparam logic [4:0] opamp_pin0 = 5'h03;
    localparam logic [4:0] opamp_pin1 = 5'h00;
    localparam logic [4:0] opamp_pin2 = 5'h06;

    typedef enum logic [2:0] {
        src_pin = 3'h0,
        src_opamp = 3'h1,
        src_temp = 3'h2,
        src_open = 3'h3,
        src_none = 3'h4
    } src_kind_t;

    typedef enum logic [1:0] {
        ref_avdd_avss = 2'h0,
        ref_ext_avss = 2'h1,
        ref_avdd_ext = 2'h2,
        ref_ext_ext = 2'h3
    } ref_sel_t;

    typedef struct packed {
        src_kind_t kind;
        logic [4:0] index;
        logic neg_an1;
    } mux_route_t;

    typedef struct packed {
        logic [15:0] data;
        logic [1:0] chan;
    } result_t;
endpackage

// file: adc_result_fifo.sv
// Small flip-flop FIFO that buffers conversion results on their way to the buffer.
`timescale 1ns/1ps
module adc_result_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage carries no reset; only the pointers and the count define what is valid.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule

// file: adc_input_decode.sv
// Decoder from a five-bit positive input code and negative bit to a route.
`timescale 1ns/1ps
module adc_input_decode (
    // Selection.
    input wire logic [4:0] pos_code,
    input wire logic neg_sel,
    input wire logic [2:0] opamp_enable,
    // Route.
    output adc_ctl_pkg::mux_route_t route
);
    wire is_pin = pos_code <= adc_ctl_pkg::pos_last_pin;
    wire is_opamp = pos_code >= adc_ctl_pkg::pos_opamp1 &&
                    pos_code <= adc_ctl_pkg::pos_opamp3;
    wire [1:0] amp = 2'(pos_code - adc_ctl_pkg::pos_opamp1);
    wire amp_on = opamp_enable[amp];
    wire [4:0] shared_pin = (amp == 2'h0) ? adc_ctl_pkg::opamp_pin0 :
                            (amp == 2'h1) ? adc_ctl_pkg::opamp_pin1 :
                            adc_ctl_pkg::opamp_pin2;
    wire [2:0] kind =
        is_pin ? adc_ctl_pkg::src_pin :
        (is_opamp && amp_on) ? adc_ctl_pkg::src_opamp :
        is_opamp ? adc_ctl_pkg::src_pin :
        (pos_code == adc_ctl_pkg::pos_temp) ? adc_ctl_pkg::src_temp :
        (pos_code == adc_ctl_pkg::pos_open) ? adc_ctl_pkg::src_open :
        adc_ctl_pkg::src_none;

    assign route.kind = adc_ctl_pkg::src_kind_t'(kind);
    assign route.index = (is_opamp && !amp_on) ? shared_pin :
                         (is_opamp ? {3'h0, amp} : pos_code);
    assign route.neg_an1 = neg_sel;
endmodule

// file: adc_front_model.sv
// Model of the converter core and result sink beside the control slice.
`timescale 1ns/1ps
module adc_front_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Sink pacing.
    input wire logic stall,
    input wire logic slow,
    // Core and sink outputs.
    output logic conv_done,
    output logic [15:0] conv_data,
    output logic res_ready
);
    logic [15:0] next_word;
    logic tick_ff;

    initial begin
        conv_done = 1'b0;
        conv_data = 16'h0000;
        next_word = 16'h0100;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= ~tick_ff;
        end
    end

    // A slow sink accepts only every other cycle, so the buffer backs up.
    assign res_ready = ~stall & (~slow | tick_ff);

    // The data word is inverted between pulses so no stale value looks valid.
    task automatic convert(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            conv_done <= 1'b1;
            conv_data <= next_word;
            next_word <= next_word + 16'h0001;
            @(posedge clk);
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// file: adc_seq_ctl_bench.sv
// Self-checking bench for the converter channel and sequencing control.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end end
module adc_seq_ctl_bench;
    logic clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [1:0] avs_response, rresp, res_chan, conv_chan;
    logic conv_done, res_valid, res_ready, res_half, use_mux_b;
    logic conv_irq, dma_advance, stall, slow;
    logic [15:0] conv_data, scan_enables, res_data, base;
    logic [4:0] ia, ib;
    adc_ctl_pkg::ref_sel_t ref_sel;
    adc_ctl_pkg::mux_route_t route_ch0;
    int miscompares, total_checks, irq_seen, dma_seen;
    logic [15:0] got_q[$];

    adc_seq_ctl #(.FIFO_DEPTH(4)) i_dut (.clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .conv_done(conv_done), .conv_data(conv_data),
        .scan_enables(scan_enables), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data), .res_chan(res_chan),
        .res_half(res_half), .ref_sel(ref_sel), .route_ch0(route_ch0),
        .conv_chan(conv_chan), .use_mux_b(use_mux_b), .conv_irq(conv_irq),
        .dma_advance(dma_advance));
    adc_front_model i_core (.clk(clk), .reset(reset), .stall(stall),
        .slow(slow), .conv_done(conv_done), .conv_data(conv_data),
        .res_ready(res_ready));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (conv_irq === 1'b1) irq_seen++;
        if (dma_advance === 1'b1) dma_seen++;
        if (res_valid === 1'b1 && res_ready === 1'b1) got_q.push_back(res_data);
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The request is held until waitrequest is seen low, as the bus demands.
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdata = avs_readdata;
        rresp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
        `CHK(n < 50, 1'b1);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 16'h0000);
    endtask

    task automatic re_reset();
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask

    function automatic adc_ctl_pkg::src_kind_t kind_of(logic [4:0] c, logic on);
        if (c <= 5'h0f) return adc_ctl_pkg::src_pin;
        if (c >= 5'h18 && c <= 5'h1a) begin
            return on ? adc_ctl_pkg::src_opamp : adc_ctl_pkg::src_pin;
        end
        if (c == 5'h1e) return adc_ctl_pkg::src_temp;
        if (c == 5'h1f) return adc_ctl_pkg::src_open;
        return adc_ctl_pkg::src_none;
    endfunction

    function automatic logic [4:0] pin_of(logic [4:0] c);
        if (c <= 5'h0f) return c;
        if (c == 5'h18) return adc_ctl_pkg::opamp_pin0;
        if (c == 5'h19) return adc_ctl_pkg::opamp_pin1;
        return adc_ctl_pkg::opamp_pin2;
    endfunction

    task automatic t_regs();
        rd(adc_ctl_pkg::ctrl2_off);
        `CHK(rdata, 32'h0000_0000);
        rd(4'h2);
        `CHK(rresp, 2'h2);
        `CHK(rdata, 32'h0000_0000);
        wr(adc_ctl_pkg::ctrl2_off, 16'hffff);
        rd(adc_ctl_pkg::ctrl2_off);
        `CHK(rdata[15:0], 16'he77f);
        avs_byteenable <= 4'h1;
        wr(adc_ctl_pkg::ctrl2_off, 16'h0000);
        avs_byteenable <= 4'h3;
        rd(adc_ctl_pkg::ctrl2_off);
        `CHK(rdata[15:0], 16'he700);
        for (int c = 0; c < 8; c++) begin
            wr(adc_ctl_pkg::ctrl2_off, 16'(c) << 13);
            repeat (2) @(posedge clk);
            `CHK(ref_sel, (c >= 4) ? 2'h0 : 2'(c));
        end
    endtask

    task automatic t_route();
        logic [4:0] c;
        for (int op = 0; op < 2; op++) begin
            wr(adc_ctl_pkg::ctrl2_off, 16'h0000);
            wr(adc_ctl_pkg::ctrl_off, (op == 1) ? 16'h001c : 16'h0000);
            for (int k = 0; k < 32; k++) begin
                c = 5'(k);
                wr(adc_ctl_pkg::chsel_off, {8'h00, c[0], 2'b00, c});
                repeat (2) @(posedge clk);
                `CHK(route_ch0.kind, kind_of(c, op == 1));
                `CHK(route_ch0.neg_an1, c[0]);
                if (kind_of(c, op == 1) == adc_ctl_pkg::src_pin) begin
                    `CHK(route_ch0.index, pin_of(c));
                end
            end
        end
    endtask

    task automatic t_count(input logic [1:0] cs, input logic tw);
        int n;
        n = tw ? 1 : (cs == 2'h0) ? 1 : (cs == 2'h1) ? 2 : 4;
        re_reset();
        wr(adc_ctl_pkg::ctrl_off, {15'h0000, tw});
        wr(adc_ctl_pkg::ctrl2_off, {6'h00, cs, 8'h00});
        rd(adc_ctl_pkg::ctrl2_off);
        `CHK(rdata[9:8], tw ? 2'h0 : cs);
        for (int k = 1; k <= 5; k++) begin
            i_core.convert(1);
            `CHK(conv_chan, 2'(k % n));
        end
    endtask

    task automatic t_rate(input logic dma, input logic [4:0] r, input int k);
        int n;
        n = dma ? int'(r) + 1 : int'(r[3:0]) + 1;
        re_reset();
        wr(adc_ctl_pkg::ctrl_off, {14'h0000, dma, 1'b0});
        wr(adc_ctl_pkg::ctrl2_off, {9'h000, r, 2'b00});
        irq_seen = 0;
        dma_seen = 0;
        i_core.convert(k);
        repeat (3) @(posedge clk);
        if (dma) begin
            `CHK(dma_seen, k / n);
        end else begin
            `CHK(irq_seen, k / n);
            `CHK(dma_seen, 0);
        end
    endtask

    task automatic t_fill_scan();
        re_reset();
        wr(adc_ctl_pkg::ctrl2_off, 16'h0006);
        for (int k = 0; k < 4; k++) begin
            rd(adc_ctl_pkg::ctrl2_off);
            `CHK(rdata[7], 1'(k % 2));
            i_core.convert(2);
        end
        re_reset();
        scan_enables <= 16'h0024;
        wr(adc_ctl_pkg::ctrl2_off, 16'h0400);
        i_core.convert(1);
        ia = route_ch0.index;
        i_core.convert(1);
        ib = route_ch0.index;
        `CHK((ia ^ ib), 5'h07);
        `CHK((ia == 5'h02 || ia == 5'h05), 1'b1);
        i_core.convert(1);
        `CHK(route_ch0.index, ia);
        scan_enables <= 16'h0000;
    endtask

    task automatic t_fifo();
        re_reset();
        stall <= 1'b1;
        base = i_core.next_word;
        got_q.delete();
        i_core.convert(8);
        rd(adc_ctl_pkg::status_off);
        `CHK(rdata[2], 1'b1);
        stall <= 1'b0;
        slow <= 1'b1;
        repeat (40) @(posedge clk);
        `CHK(got_q.size() >= 4 && got_q.size() < 8, 1'b1);
        `CHK(got_q[0], base);
        `CHK(got_q[1], base + 16'h0001);
        wr(adc_ctl_pkg::status_off, 16'h0004);
        rd(adc_ctl_pkg::status_off);
        `CHK(rdata[2], 1'b0);
        slow <= 1'b0;
    endtask

    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end

    initial begin
        reset = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h3;
        scan_enables = 16'h0000;
        stall = 1'b0;
        slow = 1'b0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_regs();
        t_route();
        t_count(2'h0, 1'b0);
        t_count(2'h1, 1'b0);
        t_count(2'h2, 1'b0);
        t_count(2'h3, 1'b0);
        t_count(2'h3, 1'b1);
        t_rate(1'b0, 5'h13, 8);
        t_rate(1'b0, 5'h00, 3);
        t_rate(1'b0, 5'h1f, 16);
        t_rate(1'b1, 5'h13, 40);
        t_rate(1'b1, 5'h1f, 32);
        t_rate(1'b1, 5'h00, 3);
        t_fill_scan();
        t_fifo();
        give_verdict();
    end
endmodule
